/* File: billing_tone_generator_test.sv */
`timescale 1ns/10ps
`include "btg_params.svh"
module billing_tone_generator_test;
   import btg_pkg::*;
   localparam int TICK = 64;
   logic i_mclk = 1'b0;
   logic i_srst = 1'b1;
   btg_ahb_req_t req = '0;
   btg_ahb_req_t ahb;
   logic [31:0] hwdata = 32'h0;
   logic clip = 1'b0;
   logic [31:0] o_hrdata, rd, v1, step;
   logic o_hreadyout, o_hresp, o_irq;
   logic signed [15:0] o_dac, tx;
   int num_errors = 0;
   int checks_done = 0;
   assign ahb = {req[$bits(req)-1:1], o_hreadyout};
   btg_top #(.FAST_DIV(8)) dut_u (.i_mclk(i_mclk), .i_srst(i_srst), .i_ahb(ahb),
      .i_hwdata(hwdata), .i_tx_sample(tx), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
      .o_hresp(o_hresp), .o_dac(o_dac), .o_irq(o_irq));
   btg_line_model line_u (.i_mclk(i_mclk), .i_dac(o_dac), .i_clip(clip), .o_tx(tx));
   initial begin
      forever #2 i_mclk = ~i_mclk;
   end
   function automatic logic [31:0] lo16(input logic [31:0] v);
      return {16'h0000, v[15:0]};
   endfunction : lo16
   task automatic close_out();
      if (num_errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      req <= '{2'b10, {24'h000000, a}, wr, 3'b010, 1'b1, 1'b1};
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      req <= '0;
      hwdata <= d;
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      rd = o_hrdata;
   endtask : xfer
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(what, rd, exp);
   endtask : rchk
   initial begin
      repeat (20000) @(posedge i_mclk);
      num_errors++;
      close_out();
   end
   initial begin
      void'($urandom(32'h3903620F));
      repeat (3) @(posedge i_mclk);
      i_srst <= 1'b0;
      chk("irq", {31'h0, o_irq}, 32'h0);
      chk("dac", {16'h0000, o_dac}, 32'h0);
      rchk("ctrl", `BTG_OFS_CTRL, 32'h0);
      rchk("volume", `BTG_OFS_TXS, 32'h0);
      for (int i = 0; i < 6; i++) begin
         v1 = $urandom;
         xfer(1'b1, 8'(4 * i), v1);
         rchk("reg", 8'(4 * i), lo16(v1));
      end
      xfer(1'b1, 8'h30, 32'hFFFF_FFFF);
      rchk("unmapped", 8'h30, 32'h0);
      step = ($urandom % 32'h3F) + 32'h1;
      xfer(1'b1, `BTG_OFS_THR, 32'h1000);
      xfer(1'b1, `BTG_OFS_RAMP, step);
      xfer(1'b1, `BTG_OFS_CTRL, 32'h1);
      repeat (5 * TICK) @(posedge i_mclk);
      xfer(1'b0, `BTG_OFS_TXS, 32'h0);
      chk("step multiple", {31'h0, rd % step == 0 && rd != 0}, 32'h1);
      clip <= 1'b1;
      repeat (TICK) @(posedge i_mclk);
      xfer(1'b0, `BTG_OFS_TXS, 32'h0);
      v1 = rd;
      repeat (3 * TICK) @(posedge i_mclk);
      rchk("frozen", `BTG_OFS_TXS, v1);
      clip <= 1'b0;
      xfer(1'b1, `BTG_OFS_RAMP, 32'h4000);
      repeat (4 * TICK) @(posedge i_mclk);
      rchk("ceiling", `BTG_OFS_TXS, {16'h0000, `BTG_VOL_MAX});
      rchk("present", `BTG_OFS_CTRL, 32'h9);
      xfer(1'b1, `BTG_OFS_CTRL, 32'h0);
      repeat (4 * TICK) @(posedge i_mclk);
      rchk("decay", `BTG_OFS_TXS, 32'h0);
      rchk("gone", `BTG_OFS_CTRL, 32'h0);
      chk("dac off", {16'h0000, o_dac}, 32'h0);
      xfer(1'b1, `BTG_OFS_ONT, 32'h2);
      xfer(1'b1, `BTG_OFS_OFFT, 32'h3);
      xfer(1'b1, `BTG_OFS_IEN, 32'h0);
      xfer(1'b1, `BTG_OFS_CTRL, 32'h7);
      repeat (13 * TICK) @(posedge i_mclk);
      rchk("status", `BTG_OFS_IVEC, 32'h3);
      chk("masked irq", {31'h0, o_irq}, 32'h0);
      xfer(1'b1, `BTG_OFS_IEN, 32'h2);
      repeat (2) @(posedge i_mclk);
      chk("irq", {31'h0, o_irq}, 32'h1);
      xfer(1'b1, `BTG_OFS_CTRL, 32'h0);
      repeat (4 * TICK) @(posedge i_mclk);
      xfer(1'b1, `BTG_OFS_IVEC, 32'h2);
      rchk("cleared", `BTG_OFS_IVEC, 32'h1);
      repeat (2) @(posedge i_mclk);
      chk("irq clear", {31'h0, o_irq}, 32'h0);
      close_out();
   end
endmodule : billing_tone_generator_test

/* File: btg_line_model.sv */
`timescale 1ns/10ps
module btg_line_model (
   input wire logic i_mclk,
   input wire logic signed [15:0] i_dac,
   input wire logic i_clip,
   output logic signed [15:0] o_tx
);
   // Transmit path echoes a small share of the tone, or a loud overload on demand
   always_ff @(posedge i_mclk) begin
      o_tx <= i_clip ? 16'sh7000 : (i_dac >>> 4);
   end
endmodule : btg_line_model

/* File: btg_params.svh */
`ifndef BTG_PARAMS_SVH
`define BTG_PARAMS_SVH
`define BTG_OFS_FREQ 8'h00
`define BTG_OFS_AMPL 8'h04
`define BTG_OFS_RAMP 8'h08
`define BTG_OFS_ONT 8'h0C
`define BTG_OFS_OFFT 8'h10
`define BTG_OFS_THR 8'h14
`define BTG_OFS_CTRL 8'h18
`define BTG_OFS_IVEC 8'h1C
`define BTG_OFS_IEN 8'h20
`define BTG_OFS_TXS 8'h24
`define BTG_CTRL_EN 0
`define BTG_CTRL_TAEN 1
`define BTG_CTRL_OFF_TIMER_ENABLE 2
`define BTG_CTRL_PRES 3
`define BTG_IRQ_TA 0
`define BTG_IRQ_TI 1
`define BTG_VOL_MAX 16'h7FFF
`define BTG_CLK_HZ 250000000
`define BTG_FAST_HZ 64000
`define BTG_SLOW_HZ 8000
`define BTG_FAST_DIV (`BTG_CLK_HZ / `BTG_FAST_HZ)
`define BTG_SLOW_RATIO (`BTG_FAST_HZ / `BTG_SLOW_HZ)
`endif

/* File: btg_pkg.sv */
package btg_pkg;
   typedef struct packed {
      logic [1:0] htrans;
      logic [31:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic hsel;
      logic hready;
   } btg_ahb_req_t;
   typedef enum logic [0:0] {
      BTG_ON = 1'b0,
      BTG_OFF = 1'b1
   } btg_phase_t;
endpackage : btg_pkg

/* File: btg_top.sv */
// Contract
// R1 - Recursive oscillator iterated at 64 kHz
// R2 - Output is oscillator times envelope volume
// R3 - Add ramp step each 8 kHz tick
// R4 - Volume starts zero, saturates at 7FFF
// R5 - Clip over threshold freezes upward ramp
// R6 - When off, volume ramps down to zero
// R7 - Sixteen bit on timer, 125 us units
// R8 - Sixteen bit off timer, 125 us units
// R9 - Separate enable and pending bits per timer
// R10 - Sixteen bit clip threshold register
// R11 - Readable waveform present bit
// R12 - Control bit enables on timer
// R13 - Off timer enable and overall enable
// R14 - Timer expiry raises enabled interrupt
// R15 - Alternate phases, reload opposite timer
// R16 - Software loads coefficients per formula
`timescale 1ns/10ps
`include "btg_params.svh"
module btg_top #(
   parameter int FAST_DIV = `BTG_FAST_DIV
) (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire btg_pkg::btg_ahb_req_t i_ahb,
   input wire logic [31:0] i_hwdata,
   input wire logic signed [15:0] i_tx_sample,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic signed [15:0] o_dac,
   output logic o_irq
);
   import btg_pkg::*;
   logic [15:0] freq_reg, ampl_reg, ramp_reg, ont_reg, offt_reg, thr_reg;
   logic en_reg, taen_reg, off_timer_enable_reg, pres_reg;
   logic [1:0] ivec_reg, ien_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [15:0] div_reg;
   logic [2:0] sub_reg;
   logic fast_tick, slow_tick;
   logic signed [15:0] y1_reg, y2_reg, vol_reg;
   logic [15:0] cnt_reg;
   btg_phase_t phase_reg;
   logic gate_on;
   logic clip;
   logic ta_exp, ti_exp;
   logic [1:0] ev;
   logic signed [31:0] osc_prod, dac_prod;
   logic signed [16:0] osc_next;
   logic [16:0] vol_up;
   logic wr;
   assign wr = wr_pend_reg;
   // Bus slave: zero wait states, always OKAY
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= i_ahb.hsel & i_ahb.hready & i_ahb.htrans[1] & i_ahb.hwrite;
         wr_addr_reg <= i_ahb.haddr[7:0];
      end
   end
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         freq_reg <= 16'h0000;
         ampl_reg <= 16'h0000;
         ramp_reg <= 16'h0000;
         ont_reg <= 16'h0000;
         offt_reg <= 16'h0000;
         thr_reg <= 16'h0000;
         en_reg <= 1'b0;
         taen_reg <= 1'b0;
         off_timer_enable_reg <= 1'b0;
         ien_reg <= 2'h0;
      end else if (wr) begin
         unique case (wr_addr_reg)
            `BTG_OFS_FREQ: freq_reg <= i_hwdata[15:0];
            `BTG_OFS_AMPL: ampl_reg <= i_hwdata[15:0];
            `BTG_OFS_RAMP: ramp_reg <= i_hwdata[15:0];
            `BTG_OFS_ONT: ont_reg <= i_hwdata[15:0]; // R7
            `BTG_OFS_OFFT: offt_reg <= i_hwdata[15:0]; // R8
            `BTG_OFS_THR: thr_reg <= i_hwdata[15:0]; // R10
            `BTG_OFS_CTRL: begin
               en_reg <= i_hwdata[`BTG_CTRL_EN]; // R13
               taen_reg <= i_hwdata[`BTG_CTRL_TAEN]; // R12
               off_timer_enable_reg <= i_hwdata[`BTG_CTRL_OFF_TIMER_ENABLE]; // R13
            end
            `BTG_OFS_IEN: ien_reg <= i_hwdata[1:0]; // R9
            default: ;
         endcase
      end
   end
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_hrdata <= 32'h00000000;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         if (i_ahb.hsel & i_ahb.hready & i_ahb.htrans[1] & ~i_ahb.hwrite) begin
            unique case (i_ahb.haddr[7:0])
               `BTG_OFS_FREQ: o_hrdata <= {16'h0000, freq_reg};
               `BTG_OFS_AMPL: o_hrdata <= {16'h0000, ampl_reg};
               `BTG_OFS_RAMP: o_hrdata <= {16'h0000, ramp_reg};
               `BTG_OFS_ONT: o_hrdata <= {16'h0000, ont_reg};
               `BTG_OFS_OFFT: o_hrdata <= {16'h0000, offt_reg};
               `BTG_OFS_THR: o_hrdata <= {16'h0000, thr_reg};
               `BTG_OFS_CTRL: o_hrdata <= {28'h0000000, pres_reg, off_timer_enable_reg,
                                          taen_reg, en_reg}; // R11
               `BTG_OFS_IVEC: o_hrdata <= {30'h00000000, ivec_reg};
               `BTG_OFS_IEN: o_hrdata <= {30'h00000000, ien_reg};
               `BTG_OFS_TXS: o_hrdata <= {16'h0000, vol_reg};
               default: o_hrdata <= 32'h00000000;
            endcase
         end
      end
   end
   // Sample rate strobes
   assign fast_tick = (div_reg == 16'(FAST_DIV - 1));
   assign slow_tick = fast_tick & (sub_reg == 3'(`BTG_SLOW_RATIO - 1));
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         div_reg <= 16'h0000;
         sub_reg <= 3'h0;
      end else begin
         div_reg <= fast_tick ? 16'h0000 : div_reg + 16'h0001;
         if (fast_tick) begin
            sub_reg <= sub_reg + 3'h1;
         end
      end
   end
   // Recursive sinusoid: y = 2*c*y1 - y2, c in Q14
   assign osc_prod = $signed(freq_reg) * y1_reg;
   assign osc_next = 17'(osc_prod >>> 13) - 17'(y2_reg);
   always_ff @(posedge i_mclk) begin
      if (i_srst | ~en_reg) begin
         y1_reg <= 16'h0000;
         y2_reg <= 16'h0000;
      end else if (fast_tick) begin // R1
         if (y1_reg == 16'h0000 && y2_reg == 16'h0000) begin
            y1_reg <= $signed(ampl_reg);
            y2_reg <= 16'h0000;
         end else begin
            y1_reg <= osc_next[15:0];
            y2_reg <= y1_reg;
         end
      end
   end
   // Cadence phase and timers
   assign gate_on = en_reg & (phase_reg == BTG_ON);
   assign ta_exp = en_reg & taen_reg & (phase_reg == BTG_ON) & slow_tick & (cnt_reg == 16'h0000);
   assign ti_exp = en_reg & off_timer_enable_reg & (phase_reg == BTG_OFF) & slow_tick & (cnt_reg == 16'h0000);
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         phase_reg <= BTG_ON;
         cnt_reg <= 16'h0000;
      end else if (~en_reg) begin
         phase_reg <= BTG_ON;
         cnt_reg <= ont_reg; // R7
      end else if (slow_tick) begin
         if (ta_exp) begin // R15
            phase_reg <= off_timer_enable_reg ? BTG_OFF : BTG_ON;
            cnt_reg <= off_timer_enable_reg ? offt_reg : ont_reg;
         end else if (ti_exp) begin // R15
            phase_reg <= BTG_ON;
            cnt_reg <= ont_reg;
         end else if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001; // R7 R8
         end
      end else if (cnt_reg == 16'h0000 && phase_reg == BTG_ON && !taen_reg) begin
         cnt_reg <= ont_reg;
      end
   end
   // Envelope
   assign clip = ($signed(i_tx_sample) < 0 ? 16'(-i_tx_sample) : i_tx_sample) > thr_reg; // R5
   assign vol_up = 17'(vol_reg) + 17'(ramp_reg);
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         vol_reg <= 16'h0000; // R4
      end else if (slow_tick) begin
         if (gate_on) begin
            if (!clip) begin // R5
               vol_reg <= (vol_up > 17'(`BTG_VOL_MAX)) ? `BTG_VOL_MAX : vol_up[15:0]; // R3 R4
            end
         end else begin
            vol_reg <= (vol_reg > ramp_reg) ? vol_reg - ramp_reg : 16'h0000; // R6
         end
      end
   end
   assign dac_prod = y1_reg * vol_reg;
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_dac <= 16'h0000;
         pres_reg <= 1'b0;
      end else begin
         o_dac <= dac_prod[30:15]; // R2
         pres_reg <= (vol_reg != 16'h0000); // R11
      end
   end
   // Interrupts: set wins over write-one-to-clear
   assign ev = {ti_exp, ta_exp};
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         ivec_reg <= 2'h0;
         o_irq <= 1'b0;
      end else begin
         ivec_reg <= (ivec_reg & ~((wr && wr_addr_reg == `BTG_OFS_IVEC) ? i_hwdata[1:0] : 2'h0))
                     | ev; // R9 R14
         o_irq <= |(ivec_reg & ien_reg); // R14
      end
   end
   property p_sat;
      @(posedge i_mclk) disable iff (i_srst) 1'b1 |-> (vol_reg <= `BTG_VOL_MAX);
   endproperty
   a_sat: assert property (p_sat) else $error("volume above ceiling"); // R4
   property p_down;
      @(posedge i_mclk) disable iff (i_srst) (slow_tick && !gate_on && vol_reg != 0 && ramp_reg != 0) |=> (vol_reg < $past(vol_reg));
   endproperty
   a_down: assert property (p_down) else $error("volume not ramping down"); // R6
   property p_clip;
      @(posedge i_mclk) disable iff (i_srst) (slow_tick && gate_on && clip) |=> (vol_reg == $past(vol_reg));
   endproperty
   a_clip: assert property (p_clip) else $error("ramp not frozen on clip"); // R5
   property p_up;
      @(posedge i_mclk) disable iff (i_srst) (slow_tick && gate_on && !clip && vol_reg < 16'h7000 && ramp_reg != 0 && ramp_reg < 16'h0800) |=> (vol_reg == $past(vol_reg) + $past(ramp_reg));
   endproperty
   a_up: assert property (p_up) else $error("ramp step wrong"); // R3
   property p_ta;
      @(posedge i_mclk) disable iff (i_srst) ta_exp |=> ivec_reg[0];
   endproperty
   a_ta: assert property (p_ta) else $error("on timer pending missing"); // R9
   property p_irq;
      @(posedge i_mclk) disable iff (i_srst) (ivec_reg & ien_reg) != 2'h0 |=> o_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq not raised"); // R14
   property p_phase;
      @(posedge i_mclk) disable iff (i_srst) (ta_exp && off_timer_enable_reg && en_reg) |=> (phase_reg == BTG_OFF && cnt_reg == $past(offt_reg));
   endproperty
   a_phase: assert property (p_phase) else $error("off phase not loaded"); // R15
   property p_pres;
      @(posedge i_mclk) disable iff (i_srst) (vol_reg != 0) |=> pres_reg;
   endproperty
   a_pres: assert property (p_pres) else $error("present flag wrong"); // R11
   property p_rate;
      @(posedge i_mclk) disable iff (i_srst) slow_tick |-> fast_tick;
   endproperty
   a_rate: assert property (p_rate) else $error("slow tick off grid"); // R1
   // Further checks
   property p_fast_wrap;
      @(posedge i_mclk) disable iff (i_srst)
         fast_tick
         |=> (div_reg == 16'h0000);
   endproperty
   a_fast_wrap: assert property (p_fast_wrap) else $error("fast divider not restarted"); // R1

   property p_slow_grid;
      @(posedge i_mclk) disable iff (i_srst)
         slow_tick
         |-> (sub_reg == 3'h7);
   endproperty
   a_slow_grid: assert property (p_slow_grid) else $error("slow tick not every eighth"); // R3

   property p_osc_hold;
      @(posedge i_mclk) disable iff (i_srst)
         (!fast_tick && en_reg)
         |=> (!en_reg || $stable(y1_reg));
   endproperty
   a_osc_hold: assert property (p_osc_hold) else $error("oscillator moved off tick"); // R1

   property p_osc_shift;
      @(posedge i_mclk) disable iff (i_srst)
         (fast_tick && en_reg && (y1_reg != 16'h0000 || y2_reg != 16'h0000))
         |=> (!en_reg || y2_reg == $past(y1_reg));
   endproperty
   a_osc_shift: assert property (p_osc_shift) else $error("oscillator history not shifted"); // R1

   property p_dac;
      @(posedge i_mclk) disable iff (i_srst)
         1'b1
         |=> (o_dac == 16'($past(dac_prod) >>> 15));
   endproperty
   a_dac: assert property (p_dac) else $error("dac not tone times volume"); // R2

   property p_dac_zero;
      @(posedge i_mclk) disable iff (i_srst)
         (vol_reg == 16'h0000)
         |=> (o_dac == 16'h0000);
   endproperty
   a_dac_zero: assert property (p_dac_zero) else $error("dac active at zero volume"); // R2

   property p_vol_hold;
      @(posedge i_mclk) disable iff (i_srst)
         !slow_tick
         |=> $stable(vol_reg);
   endproperty
   a_vol_hold: assert property (p_vol_hold) else $error("volume moved off tick"); // R3

   property p_ceil;
      @(posedge i_mclk) disable iff (i_srst)
         (slow_tick && gate_on && !clip && vol_up > 17'h07FFF)
         |=> (vol_reg == 16'h7FFF);
   endproperty
   a_ceil: assert property (p_ceil) else $error("volume not saturated"); // R4

   property p_floor;
      @(posedge i_mclk) disable iff (i_srst)
         (slow_tick && !gate_on && vol_reg <= ramp_reg)
         |=> (vol_reg == 16'h0000);
   endproperty
   a_floor: assert property (p_floor) else $error("volume not floored at zero"); // R6

   property p_quiet;
      @(posedge i_mclk) disable iff (i_srst)
         (i_tx_sample == 16'sh0000)
         |-> !clip;
   endproperty
   a_quiet: assert property (p_quiet) else $error("clip on silent line"); // R10

   property p_ti;
      @(posedge i_mclk) disable iff (i_srst)
         ti_exp
         |=> ivec_reg[1];
   endproperty
   a_ti: assert property (p_ti) else $error("off timer pending missing"); // R9

   property p_on_reload;
      @(posedge i_mclk) disable iff (i_srst)
         ti_exp
         |=> (phase_reg == BTG_ON && cnt_reg == $past(ont_reg));
   endproperty
   a_on_reload: assert property (p_on_reload) else $error("on phase not loaded"); // R15

   property p_count;
      @(posedge i_mclk) disable iff (i_srst)
         (slow_tick && en_reg && !ta_exp && !ti_exp && cnt_reg != 16'h0000)
         |=> (cnt_reg == $past(cnt_reg) - 16'h0001);
   endproperty
   a_count: assert property (p_count) else $error("cadence timer not counting"); // R7

   property p_irq_low;
      @(posedge i_mclk) disable iff (i_srst)
         ((ivec_reg & ien_reg) == 2'h0)
         |=> !o_irq;
   endproperty
   a_irq_low: assert property (p_irq_low) else $error("irq without unmasked status"); // R14

   property p_clear;
      @(posedge i_mclk) disable iff (i_srst)
         (wr && wr_addr_reg == `BTG_OFS_IVEC && i_hwdata[0] && !ta_exp)
         |=> !ivec_reg[0];
   endproperty
   a_clear: assert property (p_clear) else $error("on pending not cleared"); // R9

   property p_pres_off;
      @(posedge i_mclk) disable iff (i_srst)
         (vol_reg == 16'h0000)
         |=> !pres_reg;
   endproperty
   a_pres_off: assert property (p_pres_off) else $error("present flag stuck"); // R11
endmodule : btg_top
